// ==== core/dac_counter_adc_control.sv ====
// Up/down counter, clock selection and data port feeding an 8-bit voltage DAC
`timescale 1ns/10ps
// Operation
// - Ramp conversion starts at zero and counts up each clock.
// - Comparator high inhibits the clock; counter holds the result.
// - Low pulse on reset pin clears counter; counting then resumes.
// - Tracking, input above upper threshold: count up each clock.
// - Tracking, input below lower threshold: count down each clock.
// - Both comparator outputs high: counter holds.
// - Tracking with mode low stops at full-scale or zero, no cycling.
// - DAC word comes from counter or data port.
// - Mode high wraps 255 to 0 upward and 0 to 255 downward.
// - Mode low halts at the limit in the counting direction.
// - Mode high, both direction pins low: triangle between zero and full-scale.
// - Reset pin clears counter always, but leaves port-driven DAC word alone.
module dac_counter_adc_control #(
   parameter logic [dac_ctl_pkg::DIV_W-1:0] DIV_DEFAULT = dac_ctl_pkg::DIVIDER_RESET
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [dac_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [dac_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Control pins
   input wire dac_ctl_pkg::ctl_pins_t ctl_pins,
   // Two-way data port
   input wire logic [7:0] data_port_in,
   output logic [7:0] data_port_out,
   output logic data_port_oe,
   // Word applied to the DAC ladder
   output logic [7:0] dac_code
);
   import dac_ctl_pkg::*;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // -----------------------------------------------------------------
   // Pin synchronisation
   // -----------------------------------------------------------------
   ctl_pins_t pins;
   logic [7:0] port_level;

   pin_sync #(
      .W($bits(ctl_pins_t) + 8),
      .RST({CTL_IDLE, COUNT_ZERO})
   ) u_pin_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({ctl_pins, data_port_in}),
      .sync_out({pins, port_level})
   );

   logic dac_mode;
   logic up_only;
   logic down_only;
   logic both_low;
   assign dac_mode = !pins.mode && !pins.down_n && !pins.up_n;
   assign up_only = !pins.up_n && pins.down_n;
   assign down_only = pins.up_n && !pins.down_n;
   assign both_low = pins.mode && !pins.up_n && !pins.down_n;

   // -----------------------------------------------------------------
   // Count clock: internal divider or external pin edge
   // -----------------------------------------------------------------
   logic ext_clk_sel;
   logic [DIV_W-1:0] divider;
   logic [7:0] count;
   logic dir_up;
   logic [DIV_W-1:0] div_cnt;
   logic ext_prev;
   logic int_tick;
   logic ext_rise;
   logic tick;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt <= DIV_DEFAULT;
      end else if (div_cnt == '0) begin
         div_cnt <= divider;
      end else begin
         div_cnt <= div_cnt - 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= pins.ext_clk;
      end
   end

   assign int_tick = (div_cnt == '0);
   assign ext_rise = pins.ext_clk && !ext_prev;
   // Comparator high gates the count clock off
   assign tick = (ext_clk_sel ? ext_rise : int_tick) && !pins.inhibit;

   // -----------------------------------------------------------------
   // Up/down counter
   // -----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || !pins.reset_n) begin
         count <= COUNT_ZERO;
         dir_up <= 1'b1;
      end else if (tick && !dac_mode) begin
         if (up_only) begin
            if (count != COUNT_FULL) begin
               count <= count + 8'h01;
            end else if (pins.mode) begin
               count <= COUNT_ZERO;
            end
         end else if (down_only) begin
            if (count != COUNT_ZERO) begin
               count <= count - 8'h01;
            end else if (pins.mode) begin
               count <= COUNT_FULL;
            end
         end else if (both_low) begin
            if (dir_up && count == COUNT_FULL) begin
               dir_up <= 1'b0;
               count <= count - 8'h01;
            end else if (!dir_up && count == COUNT_ZERO) begin
               dir_up <= 1'b1;
               count <= count + 8'h01;
            end else begin
               count <= dir_up ? count + 8'h01 : count - 8'h01;
            end
         end
         // Both direction pins high: hold stop at limits with mode low
      end
   end

   // -----------------------------------------------------------------
   // DAC source and data port
   // -----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dac_code <= COUNT_ZERO;
         data_port_out <= COUNT_ZERO;
         data_port_oe <= 1'b0;
      end else if (dac_mode) begin
         dac_code <= port_level;
         data_port_oe <= 1'b0;
      end else begin
         dac_code <= count;
         data_port_out <= count;
         data_port_oe <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite write channel
   // -----------------------------------------------------------------
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;

   assign do_write = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (aw_addr[ADDR_W-1:2] <= CODE_OFFSET[ADDR_W-1:2]) ?
                        RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_clk_sel <= CTRL_EXT_CLK_RESET;
         divider <= DIV_DEFAULT;
      end else if (do_write) begin
         if (aw_addr == CTRL_OFFSET && w_strb[0]) ext_clk_sel <= w_data[CTRL_EXT_CLK_BIT];
         if (aw_addr == DIVIDER_OFFSET && w_strb[0]) divider[7:0] <= w_data[7:0];
         if (aw_addr == DIVIDER_OFFSET && w_strb[1]) divider[15:8] <= w_data[15:8];
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite read channel
   // -----------------------------------------------------------------
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = '0;
      unique case (s_axi_araddr)
         CTRL_OFFSET: next_rdata[CTRL_EXT_CLK_BIT] = ext_clk_sel;
         DIVIDER_OFFSET: next_rdata[DIV_W-1:0] = divider;
         STATUS_OFFSET: begin
            next_rdata[7:0] = count;
            next_rdata[STATUS_DIR_UP_BIT] = dir_up;
            next_rdata[STATUS_DAC_MODE_BIT] = dac_mode;
            next_rdata[STATUS_INHIBIT_BIT] = pins.inhibit;
            next_rdata[STATUS_RESET_BIT] = !pins.reset_n;
         end
         CODE_OFFSET: begin
            next_rdata[7:0] = dac_code;
            next_rdata[CODE_PORT_LSB +: 8] = port_level;
         end
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0 &&
                         s_axi_araddr[ADDR_W-1:2] <= CODE_OFFSET[ADDR_W-1:2]) ?
                        RESP_OKAY : RESP_SLVERR;
      end else if (!s_axi_rvalid || s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   logic run;
   assign run = tick && pins.reset_n && !dac_mode;

   sequence s_at_top;
      run && both_low && dir_up && count == COUNT_FULL;
   endsequence
   sequence s_at_bottom;
      run && both_low && !dir_up && count == COUNT_ZERO;
   endsequence

   a_ramp_step_up: assert property (
      run && up_only && count != COUNT_FULL |=> count == $past(count) + 8'h01)
      else $error("counter did not step up on a count clock");
   a_inhibit_holds: assert property (
      pins.reset_n && pins.inhibit |=> $stable(count))
      else $error("counter moved while the clock was inhibited");
   a_reset_clears: assert property (
      !pins.reset_n |=> count == COUNT_ZERO && dir_up)
      else $error("reset pin did not clear the counter");
   a_track_step_down: assert property (
      run && down_only && count != COUNT_ZERO |=> count == $past(count) - 8'h01)
      else $error("counter did not step down on a count clock");
   a_deadband_hold: assert property (
      pins.reset_n && pins.up_n && pins.down_n |=> $stable(count))
      else $error("counter moved inside the deadband");
   a_limit_stop: assert property (
      run && !pins.mode && ((up_only && count == COUNT_FULL) ||
      (down_only && count == COUNT_ZERO)) |=> $stable(count))
      else $error("counter left a limit with mode low");
   a_wrap_both: assert property (
      run && pins.mode && ((up_only && count == COUNT_FULL) ||
      (down_only && count == COUNT_ZERO)) |=> count == ~$past(count))
      else $error("counter did not wrap with mode high");
   a_triangle_turn: assert property (
      s_at_top or s_at_bottom |=> dir_up != $past(dir_up) && count != $past(count))
      else $error("triangle count did not reverse at a limit");
   a_dac_source: assert property (
      dac_mode |=> dac_code == $past(port_level) && !data_port_oe)
      else $error("DAC word not taken from the data port");
   a_dac_counter: assert property (
      !dac_mode |=> dac_code == $past(count) && data_port_out == dac_code)
      else $error("DAC word not taken from the counter");

endmodule

// ==== core/dac_ctl_pkg.sv ====
// Constants and types shared by the counter converter control block
package dac_ctl_pkg;

   // -----------------------------------------------------------------
   // Register map (byte addresses)
   // -----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
   localparam logic [ADDR_W-1:0] DIVIDER_OFFSET = 4'h4;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;
   localparam logic [ADDR_W-1:0] CODE_OFFSET = 4'hc;

   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int CTRL_EXT_CLK_BIT = 0;
   localparam logic CTRL_EXT_CLK_RESET = 1'h0;
   localparam int DIV_W = 16;
   localparam logic [DIV_W-1:0] DIVIDER_RESET = 16'h00c7;
   localparam int STATUS_DIR_UP_BIT = 8;
   localparam int STATUS_DAC_MODE_BIT = 9;
   localparam int STATUS_INHIBIT_BIT = 10;
   localparam int STATUS_RESET_BIT = 11;
   localparam int CODE_PORT_LSB = 8;

   // -----------------------------------------------------------------
   // Counter limits and bus answers
   // -----------------------------------------------------------------
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   localparam logic [7:0] COUNT_FULL = 8'hff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // -----------------------------------------------------------------
   // Control pins, all asynchronous to aclk
   // -----------------------------------------------------------------
   typedef struct packed {
      logic reset_n;
      logic mode;
      logic down_n;
      logic up_n;
      logic ext_clk;
      logic inhibit;
   } ctl_pins_t;

   // Idle pins: not in reset, counter stopped
   localparam ctl_pins_t CTL_IDLE = 6'h2c;

endpackage

// ==== core/pin_sync.sv ====
// Three-stage pin synchroniser that passes a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pins in, filtered levels out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // -----------------------------------------------------------------
   // Shift chain; stage1 feeds stage2 only
   // -----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= RST;
         stage2 <= RST;
         stage3 <= RST;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // -----------------------------------------------------------------
   // Per-bit agreement filter
   // -----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync_out[i] <= RST[i];
            end else if (stage2[i] == stage3[i]) begin
               sync_out[i] <= stage3[i];
            end
         end
      end
   endgenerate

endmodule

// ==== testbench/comparator_model.sv ====
// Comparator or window comparator facing the DAC output
`timescale 1ns/10ps
module comparator_model (
   // Clock
   input wire logic aclk,
   // Analogue side: 0 ramp, 1 tracking window, 2 manual direction
   input wire logic [1:0] sel,
   input wire logic signed [9:0] vin,
   input wire logic [1:0] man_dir,
   // DAC word in LSB steps
   input wire logic [7:0] dac_code,
   // Comparator outputs
   output logic up_n,
   output logic down_n,
   output logic inhibit
);
   logic signed [9:0] dac_v;

   assign dac_v = {2'h0, dac_code};

   initial begin
      up_n = 1'b1;
      down_n = 1'b1;
      inhibit = 1'b0;
   end

   always @(posedge aclk) begin
      case (sel)
         2'h0: begin
            up_n <= 1'b0;
            down_n <= 1'b1;
            inhibit <= (dac_v > vin);
         end
         2'h1: begin
            up_n <= !(vin > dac_v);
            down_n <= !(vin < dac_v);
            inhibit <= 1'b0;
         end
         default: begin
            {down_n, up_n} <= man_dir;
            inhibit <= 1'b0;
         end
      endcase
   end
endmodule

// ==== testbench/test_dac_counter_adc_control.sv ====
// Self-checking bench for the counter converter control block
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_dac_counter_adc_control;
   import dac_ctl_pkg::*;
   logic aclk, aresetn;
   logic [3:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rsp;
   ctl_pins_t pins;
   logic pin_reset_n, pin_mode, ext_clk, up_n, down_n, inhibit;
   logic [7:0] port_drive, port_in, port_out, dac_code, held;
   logic port_oe;
   logic [1:0] sel, man_dir;
   logic signed [9:0] vin;
   int num_errors = 0;
   int samples_checked = 0;

   assign pins = {pin_reset_n, pin_mode, down_n, up_n, ext_clk, inhibit};
   assign port_in = port_oe ? port_out : port_drive;

   dac_counter_adc_control #(.DIV_DEFAULT(16'h0002)) dac_counter_adc_control_inst (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .ctl_pins(pins), .data_port_in(port_in),
      .data_port_out(port_out), .data_port_oe(port_oe), .dac_code(dac_code));

   comparator_model comparator_model_inst (.aclk(aclk), .sel(sel), .vin(vin),
      .man_dir(man_dir), .dac_code(dac_code), .up_n(up_n), .down_n(down_n),
      .inhibit(inhibit));

   // ----------------------------------------------------------------
   // Bus and wait tasks
   // ----------------------------------------------------------------
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [3:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   task automatic wait_code(input logic [7:0] v);
      while (dac_code !== v) @(posedge aclk);
   endtask

   task automatic next_code(input logic [7:0] e);
      held = dac_code;
      while (dac_code === held) @(posedge aclk);
      `CHK(dac_code, e)
   endtask

   task automatic settle_chk(input logic [7:0] e);
      wait_code(e);
      repeat (64) @(posedge aclk);
      `CHK(dac_code, e)
   endtask

   task print_verdict;
      if (num_errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      repeat (80000) @(posedge aclk);
      num_errors++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {pin_reset_n, pin_mode, ext_clk} = 3'h4;
      port_drive = 8'h00;
      sel = 2'h2;
      man_dir = 2'h3;
      vin = 10'sd0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(CTRL_OFFSET);
      `CHK(rd, 32'h00000000)
      axi_read(DIVIDER_OFFSET);
      `CHK(rd, 32'h00000002)
      axi_read(4'h2);
      `CHK({rsp, rd}, {RESP_SLVERR, 32'h00000000})
      axi_write(DIVIDER_OFFSET, 32'h0000000f);
      `CHK(rsp, RESP_OKAY)
      axi_read(DIVIDER_OFFSET);
      `CHK(rd, 32'h0000000f)
      // Ramp conversion, then a second start and an over-range input
      sel <= 2'h0;
      vin <= 10'sh40;
      pin_reset_n <= 1'b0;
      repeat (10) @(posedge aclk);
      pin_reset_n <= 1'b1;
      settle_chk(8'h41);
      vin <= 10'sh10;
      pin_reset_n <= 1'b0;
      repeat (10) @(posedge aclk);
      `CHK(dac_code, 8'h00)
      pin_reset_n <= 1'b1;
      settle_chk(8'h11);
      vin <= 10'sd300;
      pin_reset_n <= 1'b0;
      repeat (10) @(posedge aclk);
      pin_reset_n <= 1'b1;
      settle_chk(8'hff);
      // Tracking with the window comparator
      sel <= 2'h1;
      vin <= 10'sh30;
      settle_chk(8'h30);
      vin <= 10'sh50;
      settle_chk(8'h50);
      vin <= -10'sd5;
      settle_chk(8'h00);
      // Wrap and triangle with mode high
      axi_write(DIVIDER_OFFSET, 32'h00000001);
      sel <= 2'h2;
      pin_mode <= 1'b1;
      man_dir <= 2'h2;
      wait_code(8'hff);
      next_code(8'h00);
      man_dir <= 2'h0;
      wait_code(8'hff);
      next_code(8'hfe);
      wait_code(8'h00);
      next_code(8'h01);
      man_dir <= 2'h1;
      wait_code(8'h00);
      next_code(8'hff);
      man_dir <= 2'h3;
      repeat (10) @(posedge aclk);
      held = dac_code;
      repeat (40) @(posedge aclk);
      `CHK(dac_code, held)
      // External count clock
      axi_write(CTRL_OFFSET, 32'h00000001);
      man_dir <= 2'h2;
      repeat (4) begin
         repeat (8) @(posedge aclk);
         ext_clk <= 1'b1;
         repeat (8) @(posedge aclk);
         ext_clk <= 1'b0;
      end
      repeat (10) @(posedge aclk);
      `CHK(dac_code, held + 8'h04)
      axi_write(CTRL_OFFSET, 32'h00000000);
      // Data port drives the DAC; reset pin leaves it alone
      pin_mode <= 1'b0;
      man_dir <= 2'h0;
      port_drive <= 8'ha5;
      repeat (16) @(posedge aclk);
      `CHK({port_oe, dac_code}, {1'b0, 8'ha5})
      pin_reset_n <= 1'b0;
      repeat (10) @(posedge aclk);
      `CHK(dac_code, 8'ha5)
      axi_read(STATUS_OFFSET);
      `CHK(rd[7:0], COUNT_ZERO)
      `CHK(rd, 32'h00000b00)
      axi_read(CODE_OFFSET);
      `CHK(rd, 32'h0000a5a5)
      pin_reset_n <= 1'b1;
      man_dir <= 2'h3;
      repeat (10) @(posedge aclk);
      `CHK({port_oe, port_out, dac_code}, {1'b1, 8'h00, 8'h00})
      print_verdict();
   end
endmodule
